//--- rtl/ivs_pkg.sv
// Package: register map, field layout and timing constants for the vector/shadow config block
package ivs_pkg;

  // Register byte addresses (word aligned)
  localparam logic [4:0] IVS_ADDR_CTRL   = 5'h00;
  localparam logic [4:0] IVS_ADDR_SHADOW = 5'h04;
  localparam logic [4:0] IVS_ADDR_RELOAD = 5'h08;
  localparam logic [4:0] IVS_ADDR_STAT   = 5'h0C;
  localparam logic [4:0] IVS_ADDR_MASK   = 5'h10;
  localparam logic [4:0] IVS_ADDR_PROX   = 5'h14;

  // Control register fields
  localparam int IVS_POL_LSB    = 0;
  localparam int IVS_POL_W      = 5;
  localparam int IVS_THR_LSB    = 8;
  localparam int IVS_THR_W      = 3;
  localparam int IVS_MULTI_VECTOR_SELECT_BIT   = 12;
  localparam int IVS_GAP_LSB    = 16;
  localparam int IVS_GAP_W      = 7;
  localparam logic [31:0] IVS_CTRL_WMASK   = 32'h007F171F;
  localparam logic [31:0] IVS_SHADOW_WMASK = 32'hFFFFFFF1;
  localparam logic [31:0] IVS_CTRL_RST     = 32'h00000000;
  localparam logic [31:0] IVS_SHADOW_RST   = 32'h00000000;
  localparam logic [31:0] IVS_RELOAD_RST   = 32'h00000000;

  // Shadow field layout: level n at bits 4n+3..4n, single-vector bit 0
  localparam int IVS_SS_W       = 4;
  localparam int IVS_SV_BIT     = 0;
  localparam int IVS_LEVELS     = 7;

  // Gap: base stride of 8 bytes, widest gap 512 bytes
  localparam int IVS_GAP_BASE_SH = 3;
  localparam int IVS_GAP_BYTES_W = 10;

  // Event status bits
  localparam int IVS_EV_W       = 7;
  localparam int IVS_EV_EDGE    = 0;   // bits 4..0 one per external input
  localparam int IVS_EV_PROX    = 5;
  localparam int IVS_EV_BADCFG  = 6;

  // Pin filter: synchroniser depth
  localparam int IVS_SYNC_STAGES = 2;

  // Interrupt request presented by the core side
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } ivs_req_s;

  // Shadow selection result toward the core
  typedef struct packed {
    logic       use_shadow;
    logic [3:0] set;
  } ivs_shadow_s;

endpackage : ivs_pkg

//--- rtl/ivs_edge_detect.sv
// Synchronise external interrupt pins and detect the programmed edge
`timescale 1ns/1ns
module ivs_edge_detect #(
  parameter int N = 5
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [N-1:0] pin_i,
  input  wire logic [N-1:0] rising_i,
  output logic      [N-1:0] edge_o
);
  import ivs_pkg::*;

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] last_q;
  logic [N-1:0] rise_w;
  logic [N-1:0] fall_w;

  ////////////////////////////////////////////////////////////////
  // Two flops before use; only the second and third are looked at
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Polarity picks rising or falling per input
  assign rise_w = sync_q & ~last_q;
  assign fall_w = ~sync_q & last_q;
  assign edge_o = (rising_i & rise_w) | (~rising_i & fall_w);

endmodule : ivs_edge_detect

//--- rtl/ivs_config.sv
// Vectored interrupt controller configuration: mode, gap, threshold, polarity, shadow map
//
// Notes on behaviour
// - Gap field: zero gives 0 bytes, one-hot bit k gives 8 times 2^k bytes.
// - With multi-vector select clear, the gap field has no effect.
// - Control bit 12 set means multi-vector mode, clear means single vector.
// - Threshold n nonzero: requests of level n or lower start the proximity timer.
// - Threshold zero keeps requests from starting the proximity timer; a count already loaded still runs down.
// - Five polarity bits 0..4: one detects rising, zero falling edges.
// - Each level 1..7 has a four-bit shadow set; 0 and 1 valid, rest reserved.
// - Per-level shadow fields are ignored in single-vector mode.
// - Shadow register bit 0 set: single vector comes with a shadow set.
// - Unimplemented control and shadow register bits read back as zero.
// - Proximity timer trigger loads the 32-bit software reload value.
`timescale 1ns/1ns
module ivs_config #(
  parameter int EXT_IRQS = 5
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Classic Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [4:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // External interrupt pins and core request
  input  wire logic [EXT_IRQS-1:0]   ext_irq_i,
  input  wire ivs_pkg::ivs_req_s     req_i,
  // Configuration outputs
  output logic                       multi_vector_select_o,
  output logic      [9:0]            vector_gap_bytes_o,
  output ivs_pkg::ivs_shadow_s       shadow_o,
  output logic      [EXT_IRQS-1:0]   ext_edge_o,
  output logic                       prox_load_o,
  output logic      [31:0]           prox_count_o,
  output logic                       irq_o
);
  import ivs_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Functions

  // One-hot gap code to byte distance; non one-hot gives zero
  function automatic logic [IVS_GAP_BYTES_W-1:0] gap_bytes(input logic [IVS_GAP_W-1:0] g);
    logic [IVS_GAP_BYTES_W-1:0] r;
    r = '0;
    for (int k = 0; k < IVS_GAP_W; k++) begin
      if (g == IVS_GAP_W'(1 << k)) begin
        r = IVS_GAP_BYTES_W'(1 << (k + IVS_GAP_BASE_SH));
      end
    end
    return r;
  endfunction : gap_bytes

  // True when the gap code is zero or one-hot
  function automatic logic gap_legal(input logic [IVS_GAP_W-1:0] g);
    return (g & (g - IVS_GAP_W'(1))) == '0;
  endfunction : gap_legal

  // Byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel,
                                             input logic [31:0] wmask);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r & wmask;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]         ctrl_q;
  logic [31:0]         shadow_q;
  logic [31:0]         reload_q;
  logic [IVS_EV_W-1:0] stat_q;
  logic [IVS_EV_W-1:0] stat_d;
  logic [IVS_EV_W-1:0] mask_q;
  logic [31:0]         prox_q;
  logic [31:0]         rdata_d;
  logic                ack_q;
  logic                err_q;
  logic [31:0]         dat_q;
  logic                multi_vector_select_q;
  logic [9:0]          gap_q;
  ivs_shadow_s         shadow_q_out;
  logic [EXT_IRQS-1:0] edge_q;
  logic                load_q;
  logic                irq_q;

  ////////////////////////////////////////////////////////////////
  // Bus decode
  wire req_w     = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  wire hit_ctrl  = wb_adr_i == IVS_ADDR_CTRL;
  wire hit_shad  = wb_adr_i == IVS_ADDR_SHADOW;
  wire hit_rel   = wb_adr_i == IVS_ADDR_RELOAD;
  wire hit_stat  = wb_adr_i == IVS_ADDR_STAT;
  wire hit_mask  = wb_adr_i == IVS_ADDR_MASK;
  wire hit_prox  = wb_adr_i == IVS_ADDR_PROX;
  wire mapped_w  = hit_ctrl | hit_shad | hit_rel | hit_stat | hit_mask | hit_prox;
  wire wr_w      = req_w & wb_we_i & mapped_w;

  ////////////////////////////////////////////////////////////////
  // Field views
  wire                 multi_vector_select_w  = ctrl_q[IVS_MULTI_VECTOR_SELECT_BIT];
  wire [IVS_GAP_W-1:0] gap_w   = ctrl_q[IVS_GAP_LSB +: IVS_GAP_W];
  wire [IVS_THR_W-1:0] thr_w   = ctrl_q[IVS_THR_LSB +: IVS_THR_W];
  wire [EXT_IRQS-1:0]  pol_w   = ctrl_q[IVS_POL_LSB +: EXT_IRQS];
  wire                 sv_w    = shadow_q[IVS_SV_BIT];

  // Gap only takes effect in multi-vector mode
  wire [9:0] gap_bytes_w = multi_vector_select_w ? gap_bytes(gap_w) : '0;
  // Reserved gap codes are flagged in multi-vector mode; behaviour otherwise left alone
  wire       bad_gap_w   = multi_vector_select_w & ~gap_legal(gap_w);

  // Shadow selection per request level; level 0 never requests
  wire [IVS_SS_W-1:0] lvl_ss_w = shadow_q[req_i.level*IVS_SS_W +: IVS_SS_W];
  ivs_shadow_s shadow_w;
  assign shadow_w.use_shadow = multi_vector_select_w ? (req_i.valid & (req_i.level != 3'h0))
                                      : (req_i.valid & sv_w);
  assign shadow_w.set        = (multi_vector_select_w && req_i.level != 3'h0) ? lvl_ss_w
                                                               : {3'h0, sv_w};

  // Proximity trigger: nonzero threshold, level at or under it
  wire prox_trig_w = req_i.valid & (thr_w != 3'h0) & (req_i.level != 3'h0)
                     & (req_i.level <= thr_w);

  // External edge detection
  logic [EXT_IRQS-1:0] edge_w;
  ivs_edge_detect #(.N(EXT_IRQS)) u_edge (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .pin_i    (ext_irq_i),
    .rising_i (pol_w),
    .edge_o   (edge_w)
  );

  // Events: set wins over write-one-to-clear
  wire [IVS_EV_W-1:0] ev_w = {bad_gap_w, prox_trig_w, edge_w};
  wire [IVS_EV_W-1:0] w1c_w = (wr_w & hit_stat & wb_sel_i[0]) ? wb_dat_i[IVS_EV_W-1:0] : '0;
  assign stat_d = (stat_q & ~w1c_w) | ev_w;

  // Read mux; unimplemented bits already zero by write masks
  always_comb begin
    rdata_d = 32'h00000000;
    case (1'b1)
      hit_ctrl: rdata_d = ctrl_q;
      hit_shad: rdata_d = shadow_q;
      hit_rel:  rdata_d = reload_q;
      hit_stat: rdata_d = {25'h0, stat_q};
      hit_mask: rdata_d = {25'h0, mask_q};
      hit_prox: rdata_d = prox_q;
      default:  rdata_d = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q   <= IVS_CTRL_RST;
      shadow_q <= IVS_SHADOW_RST;
      reload_q <= IVS_RELOAD_RST;
      mask_q   <= '0;
    end else if (wr_w) begin
      if (hit_ctrl) ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i, IVS_CTRL_WMASK);
      if (hit_shad) shadow_q <= lane_merge(shadow_q, wb_dat_i, wb_sel_i, IVS_SHADOW_WMASK);
      if (hit_rel) reload_q <= lane_merge(reload_q, wb_dat_i, wb_sel_i, 32'hFFFFFFFF);
      if (hit_mask && wb_sel_i[0]) mask_q <= wb_dat_i[IVS_EV_W-1:0];
    end
  end

  // Status and proximity counter; reload on trigger, else count down and hold at zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stat_q <= '0;
      prox_q <= '0;
    end else begin
      stat_q <= stat_d;
      if (prox_trig_w) prox_q <= reload_q;
      else if (prox_q != 32'h0) prox_q <= prox_q - 32'h1;
    end
  end

  // Bus answer: one cycle after the request, released the cycle after
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req_w & mapped_w;
      err_q <= req_w & ~mapped_w;
      dat_q <= (req_w & ~wb_we_i & mapped_w) ? rdata_d : 32'h00000000;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      multi_vector_select_q       <= 1'b0;
      gap_q        <= '0;
      shadow_q_out <= '0;
      edge_q       <= '0;
      load_q       <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      multi_vector_select_q       <= multi_vector_select_w;
      gap_q        <= gap_bytes_w;
      shadow_q_out <= shadow_w;
      edge_q       <= edge_w;
      load_q       <= prox_trig_w;
      irq_q        <= |(stat_d & mask_q);
    end
  end

  assign wb_ack_o              = ack_q;
  assign wb_err_o              = err_q;
  assign wb_dat_o              = dat_q;
  assign multi_vector_select_o = multi_vector_select_q;
  assign vector_gap_bytes_o    = gap_q;
  assign shadow_o              = shadow_q_out;
  assign ext_edge_o            = edge_q;
  assign prox_load_o           = load_q;
  assign prox_count_o          = prox_q;
  assign irq_o                 = irq_q;

  ////////////////////////////////////////////////////////////////
  // Assertions
  property p_gap_single;
    @(posedge clk_i) disable iff (reset_i)
      !multi_vector_select_w |=> vector_gap_bytes_o == 10'h000;
  endproperty
  a_gap_single: assert property (p_gap_single) else $error("gap nonzero in single mode");

  property p_gap_value;
    @(posedge clk_i) disable iff (reset_i)
      (multi_vector_select_w && gap_w == 7'h40) |=> vector_gap_bytes_o == 10'h200;
  endproperty
  a_gap_value: assert property (p_gap_value) else $error("top gap code not 512 bytes");

  property p_mode_out;
    @(posedge clk_i) disable iff (reset_i)
      ctrl_q[12] |=> multi_vector_select_o;
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode bit not reflected");

  property p_prox_off;
    @(posedge clk_i) disable iff (reset_i)
      thr_w == 3'h0 |=> !prox_load_o;
  endproperty
  a_prox_off: assert property (p_prox_off) else $error("timer started while disabled");

  property p_prox_on;
    @(posedge clk_i) disable iff (reset_i)
      (req_i.valid && req_i.level == 3'h1 && thr_w == 3'h1) |=> prox_load_o;
  endproperty
  a_prox_on: assert property (p_prox_on) else $error("level 1 did not start timer");

  property p_reload;
    @(posedge clk_i) disable iff (reset_i)
      prox_trig_w |=> prox_count_o == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) else $error("timer not loaded with reload");

  property p_shadow_single;
    @(posedge clk_i) disable iff (reset_i)
      (!multi_vector_select_w && req_i.valid) |=> shadow_o.use_shadow == $past(sv_w) && shadow_o.set[3:1] == 3'h0;
  endproperty
  a_shadow_single: assert property (p_shadow_single) else $error("single shadow wrong");

  property p_shadow_level;
    @(posedge clk_i) disable iff (reset_i)
      (multi_vector_select_w && req_i.valid && req_i.level == 3'h7) |=> shadow_o.set == $past(shadow_q[31:28]);
  endproperty
  a_shadow_level: assert property (p_shadow_level) else $error("level 7 shadow wrong");

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (reset_i)
      (ctrl_q & ~IVS_CTRL_WMASK) == 32'h0 && shadow_q[3:1] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_gap_min;
    @(posedge clk_i) disable iff (reset_i)
      (multi_vector_select_w && gap_w == 7'h01) |=> vector_gap_bytes_o == 10'h008;
  endproperty
  a_gap_min: assert property (p_gap_min) else $error("lowest gap code not 8 bytes");

  property p_mode_single;
    @(posedge clk_i) disable iff (reset_i)
      !ctrl_q[IVS_MULTI_VECTOR_SELECT_BIT] |=> !multi_vector_select_o;
  endproperty
  a_mode_single: assert property (p_mode_single) else $error("single mode not shown");

  property p_prox_above;
    @(posedge clk_i) disable iff (reset_i)
      (req_i.valid && req_i.level > thr_w) |=> !prox_load_o;
  endproperty
  a_prox_above: assert property (p_prox_above) else $error("timer above threshold");

  property p_prox_top;
    @(posedge clk_i) disable iff (reset_i)
      (req_i.valid && req_i.level == 3'h7 && thr_w == 3'h7) |=> prox_load_o;
  endproperty
  a_prox_top: assert property (p_prox_top) else $error("level 7 did not start timer");

  property p_shadow_ignored;
    @(posedge clk_i) disable iff (reset_i)
      (!multi_vector_select_w && req_i.valid && !sv_w) |=> !shadow_o.use_shadow && shadow_o.set == 4'h0;
  endproperty
  a_shadow_ignored: assert property (p_shadow_ignored) else $error("single set nonzero");

  property p_shadow_lvl1;
    @(posedge clk_i) disable iff (reset_i)
      (multi_vector_select_w && req_i.valid && req_i.level == 3'h1) |=> shadow_o.set == $past(shadow_q[7:4]);
  endproperty
  a_shadow_lvl1: assert property (p_shadow_lvl1) else $error("level 1 shadow wrong");

  property p_ctrl_rd_zero;
    @(posedge clk_i) disable iff (reset_i)
      (req_w && !wb_we_i && hit_ctrl) |=> (wb_dat_o & ~IVS_CTRL_WMASK) == 32'h00000000;
  endproperty
  a_ctrl_rd_zero: assert property (p_ctrl_rd_zero) else $error("ctrl read bit set");

  property p_shad_rd_zero;
    @(posedge clk_i) disable iff (reset_i)
      (req_w && !wb_we_i && hit_shad) |=> wb_dat_o[3:1] == 3'h0;
  endproperty
  a_shad_rd_zero: assert property (p_shad_rd_zero) else $error("shadow read bit set");

  // No disable here: it must look at the edge right after reset lets go
  property p_reset_zero;
    @(posedge clk_i)
      $past(reset_i) |-> (ctrl_q | shadow_q) == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

endmodule : ivs_config

//--- tb/ivs_core_model.sv
// Processor core model presenting vectored interrupt requests
`timescale 1ns/1ns
module ivs_core_model (
  input  wire logic         clk_i,
  output ivs_pkg::ivs_req_s req_o
);
  import ivs_pkg::*;
  // Idle level field toggles so that nothing relies on a stale value
  initial req_o = '0;
  // A slow core waits dly cycles; a request stands for exactly one edge
  task automatic issue(input logic [2:0] lvl, input int dly);
    repeat (dly) @(posedge clk_i);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, level: lvl};
    @(posedge clk_i);
    req_o <= '{valid: 1'b0, level: ~lvl};
  endtask : issue
endmodule : ivs_core_model

//--- tb/irq_vector_shadow_config_tb_top.sv
// Testbench for the vector, threshold, polarity and shadow configuration block
`timescale 1ns/1ns
`define IVS_CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module irq_vector_shadow_config_tb_top;
  import ivs_pkg::*;
  logic        clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [4:0]  wb_adr_i, ext_irq_i, ext_edge_o, seen;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, prox_count_o, rdat;
  logic        wb_ack_o, wb_err_o, multi_vector_select_o, prox_load_o, irq_o, bus_err;
  logic [9:0]  vector_gap_bytes_o;
  ivs_req_s    core_req;
  ivs_shadow_s shadow_o;
  int          fails, num_checks;

  ivs_config i_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .ext_irq_i(ext_irq_i), .req_i(core_req), .multi_vector_select_o(multi_vector_select_o),
    .vector_gap_bytes_o(vector_gap_bytes_o), .shadow_o(shadow_o), .ext_edge_o(ext_edge_o),
    .prox_load_o(prox_load_o), .prox_count_o(prox_count_o), .irq_o(irq_o));
  ivs_core_model i_core (.clk_i(clk_i), .req_o(core_req));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict in one place; a timeout also lands here
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Classic single cycle; request held until ack or err is sampled high, giving up after 20 cycles
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    rdat = wb_dat_o;
    bus_err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!(wb_ack_o || wb_err_o)) begin
      fails++;
      conclude();
    end
  endtask : wb

  // Let registered outputs land before looking at them
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  // Drive all pins to one level and collect edge pulses over eight cycles
  task automatic watch(input logic [4:0] lvl);
    @(posedge clk_i);
    ext_irq_i <= lvl;
    seen = '0;
    repeat (8) begin
      @(posedge clk_i);
      seen |= ext_edge_o;
    end
  endtask : watch

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, read-as-zero bits, reload and an unmapped address
  task automatic t_regs();
    `IVS_CHK("mode reset", 1'b0, multi_vector_select_o)
    wb(0, IVS_ADDR_CTRL, '0);
    `IVS_CHK("ctrl reset", 32'h00000000, rdat)
    wb(0, IVS_ADDR_SHADOW, '0);
    `IVS_CHK("shadow reset", 32'h00000000, rdat)
    wb(1, IVS_ADDR_CTRL, 32'hFF80FFFF);
    wb(0, IVS_ADDR_CTRL, '0);
    `IVS_CHK("ctrl readback", 32'h0000171F, rdat)
    wb(1, IVS_ADDR_SHADOW, 32'hFFFFFFFF);
    wb(0, IVS_ADDR_SHADOW, '0);
    `IVS_CHK("shadow readback", 32'hFFFFFFF1, rdat)
    wb(1, IVS_ADDR_RELOAD, 32'hA5C30F96);
    wb(0, IVS_ADDR_RELOAD, '0);
    `IVS_CHK("reload readback", 32'hA5C30F96, rdat)
    wb(0, 5'h18, '0);
    `IVS_CHK("unmapped err", 1'b1, bus_err)
    `IVS_CHK("unmapped data", 32'h00000000, rdat)
    $display("test registers done");
  endtask : t_regs

  // Every legal gap code in multi mode, then single mode ignores it
  task automatic t_gap();
    for (int k = 0; k < 7; k++) begin
      wb(1, IVS_ADDR_CTRL, 32'h00001000 | (32'h00010000 << k));
      settle();
      `IVS_CHK("gap bytes", 10'(8 << k), vector_gap_bytes_o)
      `IVS_CHK("multi mode", 1'b1, multi_vector_select_o)
    end
    wb(1, IVS_ADDR_CTRL, 32'h00001000);
    settle();
    `IVS_CHK("gap zero", 10'h000, vector_gap_bytes_o)
    wb(1, IVS_ADDR_CTRL, 32'h00400000);
    settle();
    `IVS_CHK("single mode", 1'b0, multi_vector_select_o)
    `IVS_CHK("gap ignored", 10'h000, vector_gap_bytes_o)
    $display("test gap done");
  endtask : t_gap

  // Each threshold admits its own level; thresholds 1 to 6 also refuse the next one up
  task automatic t_thr();
    wb(1, IVS_ADDR_RELOAD, 32'h00000400);
    for (int t = 1; t < 8; t++) begin
      wb(1, IVS_ADDR_CTRL, 32'(t) << 8);
      i_core.issue(3'(t), t % 2);
      #1;
      `IVS_CHK("timer start", 1'b1, prox_load_o)
      `IVS_CHK("timer load", 32'h00000400, prox_count_o)
      if (t < 7) begin
        i_core.issue(3'(t + 1), 0);
        #1;
        `IVS_CHK("above threshold", 1'b0, prox_load_o)
      end
    end
    wb(1, IVS_ADDR_CTRL, 32'h00000000);
    i_core.issue(3'd1, 0);
    #1;
    `IVS_CHK("timer off", 1'b0, prox_load_o)
    wb(0, IVS_ADDR_STAT, '0);
    `IVS_CHK("timer event", 32'h00000020, rdat)
    $display("test threshold done");
  endtask : t_thr

  // Per-level sets in multi mode; single vector uses only bit 0
  task automatic t_shadow();
    wb(1, IVS_ADDR_CTRL, 32'h00001000);
    wb(1, IVS_ADDR_SHADOW, 32'h10101010);
    for (int l = 1; l < 8; l++) begin
      i_core.issue(3'(l), 0);
      #1;
      `IVS_CHK("level set", 4'(l % 2), shadow_o.set)
    end
    wb(1, IVS_ADDR_CTRL, 32'h00000000);
    wb(1, IVS_ADDR_SHADOW, 32'h11111110);
    i_core.issue(3'd3, 1);
    #1;
    `IVS_CHK("single no shadow", 1'b0, shadow_o.use_shadow)
    `IVS_CHK("single set ignored", 4'h0, shadow_o.set)
    wb(1, IVS_ADDR_SHADOW, 32'h00000001);
    i_core.issue(3'd3, 0);
    #1;
    `IVS_CHK("single shadow", 1'b1, shadow_o.use_shadow)
    $display("test shadow done");
  endtask : t_shadow

  // Mixed polarities, then status, mask and interrupt line
  task automatic t_edges();
    wb(1, IVS_ADDR_MASK, 32'h00000000);
    wb(1, IVS_ADDR_STAT, 32'h0000007F);
    wb(1, IVS_ADDR_CTRL, 32'h00000015);
    watch(5'h1F);
    `IVS_CHK("rising edges", 5'h15, seen)
    watch(5'h00);
    `IVS_CHK("falling edges", 5'h0A, seen)
    wb(0, IVS_ADDR_STAT, '0);
    `IVS_CHK("edge status", 32'h0000001F, rdat)
    `IVS_CHK("irq masked", 1'b0, irq_o)
    wb(1, IVS_ADDR_MASK, 32'h00000001);
    settle();
    `IVS_CHK("irq raised", 1'b1, irq_o)
    wb(1, IVS_ADDR_STAT, 32'h0000001F);
    settle();
    `IVS_CHK("irq cleared", 1'b0, irq_o)
    $display("test edges done");
  endtask : t_edges

  // Reset in mid-run wipes programmed fields; first request right after release
  task automatic t_reset();
    wb(1, IVS_ADDR_CTRL, 32'h0000171F);
    wb(1, IVS_ADDR_SHADOW, 32'hFFFFFFF1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    `IVS_CHK("mode after reset", 1'b0, multi_vector_select_o)
    wb(0, IVS_ADDR_CTRL, '0);
    `IVS_CHK("ctrl after reset", 32'h00000000, rdat)
    wb(0, IVS_ADDR_SHADOW, '0);
    `IVS_CHK("shadow after reset", 32'h00000000, rdat)
    $display("test reset done");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, time-zero values, reset and the scenario sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Guard against a hang anywhere in the run
  initial begin
    #300000;
    fails++;
    conclude();
  end

  initial begin
    fails = 0;
    num_checks = 0;
    reset_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    ext_irq_i = 5'h00;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_gap();
    t_thr();
    t_shadow();
    t_edges();
    t_reset();
    conclude();
  end
endmodule : irq_vector_shadow_config_tb_top
